/* logic/lpd_top.sv */
// Purpose: LED PWM driver control: registers, shadow update, PWM outputs
// Assumes: Registers written only through the two-wire slave port
// Notes:   One system clock; PWM step rate is a divided enable pulse
`timescale 1ns/1ps
module lpd_top
  import lpd_pkg::*;
#(
  parameter int CH = lpd_pkg::NUM_CH
)
(
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic            sclIn,
  input  wire logic            sdaIn,
  output logic                 sdaOe_b,
  input  wire logic [1:0]      addrStrap,
  input  wire logic            shutdownPin_n,
  output logic [CH-1:0]        ledChannelOutput,
  output logic [CH*6-1:0]      currentScaleCode,
  output logic                 pwmCycleStart
);
  import lpd_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The register map has room for exactly the documented channel count
  if (CH < 1 || CH > NUM_CH)
  begin : gChCheck
    $error("lpd_top: CH must lie between 1 and 18");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] chanIndex(input logic [7:0] addr,
                                           input logic [7:0] base);
    logic [7:0] diff;
    diff = addr - base;
    return diff[4:0];
  endfunction

  function automatic logic inRange(input logic [7:0] addr,
                                   input logic [7:0] lo,
                                   input logic [7:0] hi);
    return (addr >= lo) && (addr <= hi);
  endfunction

  // Codes of the form 00xxxx give zero current
  function automatic logic scaleLive(input logic [5:0] code);
    return code[SCALE_ON_MSB:SCALE_ON_LSB] != 2'b00;
  endfunction

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic       wrStrobe;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic       slaveOe_b;

  // Strap and shutdown pin are asynchronous, two flops each
  logic [1:0] strapS1_r, strapS2_r;
  logic       shdnS1_r, shdnS2_r;

  always_ff @(posedge clk)
  begin
    strapS1_r <= addrStrap;
    strapS2_r <= strapS1_r;
    shdnS1_r  <= shutdownPin_n;
    shdnS2_r  <= shdnS1_r;
  end

  lpd_i2c_rx uRx (
    .clk       (clk),
    .rst_b     (rst_b),
    .sclIn     (sclIn),
    .sdaIn     (sdaIn),
    .addrStrap (strapS2_r),
    .sdaOe_b   (slaveOe_b),
    .wrStrobe  (wrStrobe),
    .wrAddr    (wrAddr),
    .wrData    (wrData)
  );

  assign sdaOe_b = slaveOe_b;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire       hitShutdown = wrStrobe && (wrAddr == REG_SHUTDOWN);
  wire       hitPwm      = wrStrobe && inRange(wrAddr, REG_PWM_FIRST, REG_PWM_LAST);
  wire       hitScale    = wrStrobe && inRange(wrAddr, REG_SCALE_FIRST, REG_SCALE_LAST);
  wire       hitGlobal   = wrStrobe && (wrAddr == REG_GLOBAL);
  wire       hitFreq     = wrStrobe && (wrAddr == REG_FREQ);
  wire       doUpdate    = wrStrobe && (wrAddr == REG_UPDATE)
                           && (wrData == CMD_TRIGGER);
  wire       doRegReset  = wrStrobe && (wrAddr == REG_RESET)
                           && (wrData == CMD_TRIGGER);
  wire [4:0] pwmIdx      = chanIndex(wrAddr, REG_PWM_FIRST);
  wire [4:0] scaleIdx    = chanIndex(wrAddr, REG_SCALE_FIRST);
  wire       clearAll    = !rst_b || doRegReset;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic softOn_r;
  logic globalOff_r;
  logic freqSel_r;

  // Shutdown state only gates outputs, never the register writes
  always_ff @(posedge clk)
  begin
    if (clearAll)
    begin
      softOn_r    <= SOFT_ON_DEFAULT;
      globalOff_r <= GLOBAL_DEFAULT;
      freqSel_r   <= FREQ_DEFAULT;
    end
    else
    begin
      if (hitShutdown)
        softOn_r <= wrData[SOFT_ON_BIT];
      if (hitGlobal)
        globalOff_r <= wrData[GLOBAL_OFF_BIT];
      if (hitFreq)
        freqSel_r <= wrData[FREQ_SEL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Duty and scale: shadow and active copies
  // ----------------------------------------------------------------
  logic [7:0]         pwmShadow_r   [CH];
  logic [7:0]         pwmActive_r   [CH];
  logic [SCALE_W-1:0] scaleShadow_r [CH];
  logic [SCALE_W-1:0] scaleActive_r [CH];

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < CH; i++)
    begin
      if (clearAll)
      begin
        pwmShadow_r[i]   <= PWM_DEFAULT;
        scaleShadow_r[i] <= SCALE_DEFAULT;
      end
      else
      begin
        if (hitPwm && pwmIdx == 5'(i))
          pwmShadow_r[i] <= wrData;
        if (hitScale && scaleIdx == 5'(i))
          scaleShadow_r[i] <= wrData[SCALE_W-1:0];
      end
    end
  end

  // Active copies change only on the update command or a reset, so a
  // multi-byte load appears on all channels at the same moment
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < CH; i++)
    begin
      if (clearAll)
      begin
        pwmActive_r[i]   <= PWM_DEFAULT;
        scaleActive_r[i] <= SCALE_DEFAULT;
      end
      else if (doUpdate)
      begin
        pwmActive_r[i]   <= pwmShadow_r[i];
        scaleActive_r[i] <= scaleShadow_r[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // PWM step divider and shared counter
  // ----------------------------------------------------------------
  localparam logic [7:0] DIV_FAST_M1 = 8'(DIV_FAST - 1);
  localparam logic [7:0] DIV_SLOW_M1 = 8'(DIV_SLOW - 1);

  logic [7:0] stepDiv_r;
  logic [7:0] pwmCnt_r;

  wire [7:0] divLimit = freqSel_r ? DIV_SLOW_M1 : DIV_FAST_M1;
  wire       stepEn   = (stepDiv_r >= divLimit);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      stepDiv_r <= 8'h00;
    else if (stepEn)
      stepDiv_r <= 8'h00;
    else
      stepDiv_r <= stepDiv_r + 8'h01;
  end

  // One counter for every channel keeps all rising edges aligned
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      pwmCnt_r <= 8'h00;
    else if (stepEn)
      pwmCnt_r <= pwmCnt_r + 8'h01;
  end

  // ----------------------------------------------------------------
  // Output gating
  // ----------------------------------------------------------------
  // Any shutdown source or the global bit darkens every channel
  wire outputsAllowed = shdnS2_r && softOn_r && !globalOff_r;

  logic [CH-1:0]   chanOn;
  logic [CH*6-1:0] scaleOut;

  for (genvar g = 0; g < CH; g++)
  begin : gChan
    wire live = outputsAllowed && scaleLive(scaleActive_r[g]);
    assign chanOn[g] = live && (pwmCnt_r < pwmActive_r[g]);
    assign scaleOut[g*6 +: 6] = live ? scaleActive_r[g] : SCALE_DEFAULT;
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ledChannelOutput <= '0;
      currentScaleCode <= '0;
      pwmCycleStart    <= 1'b0;
    end
    else
    begin
      ledChannelOutput <= chanOn;
      currentScaleCode <= scaleOut;
      pwmCycleStart    <= stepEn && (pwmCnt_r == 8'hff);
    end
  end

endmodule

/* logic/lpd_pkg.sv */
// Purpose: Constants shared by the LED PWM driver control logic
// Assumes: 100 MHz system clock, write-only two-wire register port
// Notes:   Register map, defaults, field positions and PWM timing
package lpd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_SHUTDOWN    = 8'h00;
  localparam logic [7:0] REG_PWM_FIRST   = 8'h01;
  localparam logic [7:0] REG_PWM_LAST    = 8'h12;
  localparam logic [7:0] REG_UPDATE      = 8'h13;
  localparam logic [7:0] REG_SCALE_FIRST = 8'h14;
  localparam logic [7:0] REG_SCALE_LAST  = 8'h25;
  localparam logic [7:0] REG_GLOBAL      = 8'h26;
  localparam logic [7:0] REG_FREQ        = 8'h27;
  localparam logic [7:0] REG_RESET       = 8'h2f;
  localparam logic [7:0] CMD_TRIGGER     = 8'h00;

  // ----------------------------------------------------------------
  // Fields and defaults
  // ----------------------------------------------------------------
  localparam int         SOFT_ON_BIT     = 0;
  localparam int         GLOBAL_OFF_BIT  = 0;
  localparam int         FREQ_SEL_BIT    = 0;
  localparam int         SCALE_W         = 6;
  localparam int         SCALE_ON_MSB    = 5;
  localparam int         SCALE_ON_LSB    = 4;
  localparam logic [7:0] PWM_DEFAULT     = 8'h00;
  localparam logic [5:0] SCALE_DEFAULT   = 6'h00;
  localparam logic       SOFT_ON_DEFAULT = 1'b0;
  localparam logic       GLOBAL_DEFAULT  = 1'b0;
  localparam logic       FREQ_DEFAULT    = 1'b0;
  localparam int         NUM_CH          = 18;

  // ----------------------------------------------------------------
  // Slave address and PWM timing
  // ----------------------------------------------------------------
  localparam logic [4:0] SLAVE_ADDR_HI   = 5'h1b;
  localparam int         CLK_HZ          = 100_000_000;
  localparam int         PWM_STEPS       = 256;
  localparam int         FREQ_FAST_HZ    = 23000;
  localparam int         FREQ_SLOW_HZ    = 3450;
  localparam int         DIV_FAST        = CLK_HZ / (FREQ_FAST_HZ * PWM_STEPS);
  localparam int         DIV_SLOW        = CLK_HZ / (FREQ_SLOW_HZ * PWM_STEPS);

  typedef enum logic [1:0] {LPD_IDLE, LPD_ADDR, LPD_REGPTR, LPD_DATA} lpd_phase_t;

endpackage

/* logic/lpd_i2c_rx.sv */
// Purpose: Write-only two-wire slave feeding register writes
// Assumes: SCL and SDA arrive asynchronously, strap already synchronised
// Notes:   Acknowledge pulls SDA low; no read path exists
`timescale 1ns/1ps
module lpd_i2c_rx
  import lpd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  input  wire logic [1:0] addrStrap,
  output logic            sdaOe_b,
  output logic            wrStrobe,
  output logic [7:0]      wrAddr,
  output logic [7:0]      wrData
);
  import lpd_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and line events
  // ----------------------------------------------------------------
  logic       sclS1_r, sclS2_r, sclD_r;
  logic       sdaS1_r, sdaS2_r, sdaD_r;
  lpd_phase_t phase_r;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r;
  logic [7:0] ptr_r;

  always_ff @(posedge clk)
  begin
    sclS1_r <= sclIn;
    sclS2_r <= sclS1_r;
    sclD_r  <= sclS2_r;
    sdaS1_r <= sdaIn;
    sdaS2_r <= sdaS1_r;
    sdaD_r  <= sdaS2_r;
  end

  wire sclRise   = sclS2_r & ~sclD_r;
  wire sclFall   = ~sclS2_r & sclD_r;
  wire startSeen = sclS2_r & sclD_r & sdaD_r & ~sdaS2_r;
  wire stopSeen  = sclS2_r & sclD_r & ~sdaD_r & sdaS2_r;
  wire byteDone  = sclFall && (bitCnt_r == 4'h8);
  wire ackDone   = sclFall && (bitCnt_r == 4'h9);
  // Write bit must be zero; reads are never acknowledged
  wire addrMatch = (shift_r == {SLAVE_ADDR_HI, addrStrap, 1'b0});

  // ----------------------------------------------------------------
  // Byte framing, pointer and acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    wrStrobe <= 1'b0;
    if (!rst_b || stopSeen)
    begin
      phase_r  <= LPD_IDLE;
      bitCnt_r <= 4'h0;
      sdaOe_b  <= 1'b1;
      if (!rst_b)
      begin
        shift_r <= 8'h00;
        ptr_r   <= 8'h00;
        wrAddr  <= 8'h00;
        wrData  <= 8'h00;
      end
    end
    else if (startSeen)
    begin
      phase_r  <= LPD_ADDR;
      bitCnt_r <= 4'h0;
      sdaOe_b  <= 1'b1;
    end
    else if (sclRise && phase_r != LPD_IDLE && bitCnt_r < 4'h8)
    begin
      shift_r  <= {shift_r[6:0], sdaS2_r};
      bitCnt_r <= bitCnt_r + 4'h1;
    end
    else if (byteDone)
    begin
      bitCnt_r <= 4'h9;
      case (phase_r)
        LPD_ADDR:
        begin
          phase_r <= addrMatch ? LPD_REGPTR : LPD_IDLE;
          sdaOe_b <= ~addrMatch;
        end
        LPD_REGPTR:
        begin
          ptr_r   <= shift_r;
          phase_r <= LPD_DATA;
          sdaOe_b <= 1'b0;
        end
        LPD_DATA:
        begin
          wrStrobe <= 1'b1;
          wrAddr   <= ptr_r;
          wrData   <= shift_r;
          ptr_r    <= ptr_r + 8'h01;
          sdaOe_b  <= 1'b0;
        end
        default:
        begin
          sdaOe_b <= 1'b1;
        end
      endcase
    end
    else if (ackDone)
    begin
      bitCnt_r <= 4'h0;
      sdaOe_b  <= 1'b1;
    end
  end

endmodule

/* dv/lpd_properties.sv */
// Purpose: Port checks for the LED PWM control block
// Assumes: Bound onto lpd_top, single clock domain
// Notes:   Ack bounds sized for ten-clock SCL phases
`timescale 1ns/1ps
module lpd_properties #(
  parameter int CH = 18
)
(
  input wire logic            clk,
  input wire logic            rst_b,
  input wire logic            sclIn,
  input wire logic            sdaIn,
  input wire logic            sdaOe_b,
  input wire logic [1:0]      addrStrap,
  input wire logic            shutdownPin_n,
  input wire logic [CH-1:0]   ledChannelOutput,
  input wire logic [CH*6-1:0] currentScaleCode,
  input wire logic            pwmCycleStart
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Five samples cover the two-flop sync plus output register
  sequence s_pinLow;
    !shutdownPin_n [*5];
  endsequence
  sequence s_ackHeld;
    !sdaOe_b [*8];
  endsequence

  property p_rst;
    $rose(rst_b) |-> ledChannelOutput == '0 && currentScaleCode == '0 && sdaOe_b;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not dark after reset");
  property p_pinOff;
    s_pinLow |-> ledChannelOutput == '0 && currentScaleCode == '0;
  endproperty
  a_pinOff: assert property (p_pinOff) else $error("output on during pin shutdown");
  property p_ackHold;
    $fell(sdaOe_b) |-> s_ackHeld;
  endproperty
  a_ackHold: assert property (p_ackHold) else $error("ack too short");
  property p_ackEnd;
    $fell(sdaOe_b) |-> ##[1:400] sdaOe_b;
  endproperty
  a_ackEnd: assert property (p_ackEnd) else $error("ack never released");
  property p_ackSclLow;
    $fell(sdaOe_b) |-> !sclIn;
  endproperty
  a_ackSclLow: assert property (p_ackSclLow) else $error("ack changed with SCL high");
  property p_pulse;
    pwmCycleStart |=> !pwmCycleStart [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("cycle pulses too close");

  for (genvar g = 0; g < CH; g++)
  begin : g_ch
    property p_scaleLive;
      currentScaleCode[g*6+:6] != '0 |-> currentScaleCode[g*6+4+:2] != 2'b00;
    endproperty
    a_scaleLive: assert property (p_scaleLive) else $error("zero-current code passed");
    property p_onNeedsScale;
      ledChannelOutput[g] |-> currentScaleCode[g*6+4+:2] != 2'b00;
    endproperty
    a_onNeedsScale: assert property (p_onNeedsScale) else $error("on without scale");
    property p_syncRise;
      $rose(ledChannelOutput[g]) && $stable(currentScaleCode[g*6+:6])
        |-> pwmCycleStart || $past(pwmCycleStart);
    endproperty
    a_syncRise: assert property (p_syncRise) else $error("rise off cycle start");
  end
endmodule

/* dv/lpd_host_model.sv */
// Purpose: Write-only two-wire bus master for register traffic
// Assumes: SDA has a pull-up; SCL phases of ten clocks
// Notes:   Bus idles high; SCL stands still outside frames
`timescale 1ns/1ps
module lpd_host_model (
  input wire logic clk,
  input wire logic sdaOe_b,
  output logic     sclIn,
  output logic     sdaIn
);
  logic sdaRel;

  // Wired-AND with pull-up: either side may pull low
  assign sdaIn = sdaRel & sdaOe_b;

  initial
  begin
    sclIn = 1'b1;
    sdaRel = 1'b1;
  end

  task automatic hp;
    repeat (10) @(negedge clk);
  endtask

  task automatic start;
    sdaRel = 1'b1;
    sclIn = 1'b1;
    hp();
    sdaRel = 1'b0;
    hp();
    sclIn = 1'b0;
    hp();
  endtask

  // MSB first, ack sampled at the end of the ninth SCL high phase
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sdaRel = b[i];
      hp();
      sclIn = 1'b1;
      hp();
      sclIn = 1'b0;
      hp();
    end
    sdaRel = 1'b1;
    hp();
    sclIn = 1'b1;
    hp();
    ack = !sdaIn;
    sclIn = 1'b0;
    hp();
  endtask

  task automatic stop;
    sdaRel = 1'b0;
    hp();
    sclIn = 1'b1;
    hp();
    sdaRel = 1'b1;
    hp();
  endtask
endmodule

/* dv/lpd_top_test.sv */
// Purpose: Self-checking bench for the LED PWM control block
// Assumes: Host model drives the two-wire port
// Notes:   PWM measured over one full period per check
`timescale 1ns/1ps
module lpd_top_test;
  import lpd_pkg::*;
  localparam int          CH    = NUM_CH;
  localparam logic [7:0]  DEV   = {SLAVE_ADDR_HI, 2'b10, 1'b0};
  localparam logic [31:0] DUTY  = 32'h8000ff40;
  localparam logic [31:0] SCALE = 32'h303f100f;
  logic            clk;
  logic            rst_b;
  logic            shutdownPin_n;
  logic            sclIn;
  logic            sdaIn;
  logic            sdaOe_b;
  logic            pwmCycleStart;
  logic [1:0]      addrStrap;
  logic [CH-1:0]   ledChannelOutput;
  logic [CH*6-1:0] currentScaleCode;
  int              failures;
  int              check_count;

  lpd_top #(.CH(CH)) lpd_top_inst (.clk(clk), .rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOe_b(sdaOe_b), .addrStrap(addrStrap), .shutdownPin_n(shutdownPin_n),
    .ledChannelOutput(ledChannelOutput), .currentScaleCode(currentScaleCode),
    .pwmCycleStart(pwmCycleStart));
  lpd_host_model lpd_host_model_inst (.clk(clk), .sdaOe_b(sdaOe_b), .sclIn(sclIn),
    .sdaIn(sdaIn));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Bytes go out high byte first; a refused address ends the frame
  task automatic wr(input logic [7:0] dev, input logic [7:0] ptr, input logic [31:0] d,
                    input int n);
    logic ack;
    lpd_host_model_inst.start();
    lpd_host_model_inst.sendByte(dev, ack);
    cmp({31'h0, ack}, {31'h0, dev == DEV});
    if (ack)
    begin
      lpd_host_model_inst.sendByte(ptr, ack);
      cmp({31'h0, ack}, 32'h1);
      for (int k = n - 1; k >= 0; k--)
      begin
        lpd_host_model_inst.sendByte(d[8*k+:8], ack);
        cmp({31'h0, ack}, 32'h1);
      end
    end
    lpd_host_model_inst.stop();
  endtask

  // Counts on-cycles of channels 0..3 over one period from a cycle pulse
  task automatic chkPwm(input int div, input logic [31:0] duty, input logic [3:0] live);
    int i;
    int on [4];
    on = '{default: 0};
    for (i = 0; i < 30000 && pwmCycleStart !== 1'b1; i++)
      @(negedge clk);
    if (i == 30000)
    begin
      failures++;
      end_sim();
    end
    for (i = 0; i < PWM_STEPS * div; i++)
    begin
      for (int k = 0; k < 4; k++)
        on[k] += int'(ledChannelOutput[k]);
      @(negedge clk);
    end
    cmp({31'h0, pwmCycleStart}, 32'h1);
    for (int k = 0; k < 4; k++)
      cmp(32'(on[k]), live[k] ? 32'(duty[8*(3-k)+:8] * div) : 32'h0);
  endtask

  initial
  begin
    rst_b = 1'b0;
    shutdownPin_n = 1'b1;
    addrStrap = 2'b10;
    failures = 0;
    check_count = 0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    cmp(32'(ledChannelOutput), 32'h0);
    wr({SLAVE_ADDR_HI, 2'b01, 1'b0}, REG_SHUTDOWN, 32'h01, 1);
    wr({SLAVE_ADDR_HI, 2'b10, 1'b1}, REG_SHUTDOWN, 32'h01, 1);
    wr(DEV, REG_SHUTDOWN, 32'h01, 1);
    wr(DEV, REG_PWM_FIRST, DUTY, 4);
    wr(DEV, REG_SCALE_FIRST, SCALE, 4);
    repeat (4) @(negedge clk);
    cmp(32'(currentScaleCode), 32'h0);
    wr(DEV, REG_UPDATE, 32'h00, 1);
    repeat (4) @(negedge clk);
    cmp(32'(currentScaleCode[23:0]), {8'h0, 6'h00, 6'h10, 6'h3f, 6'h30});
    chkPwm(DIV_FAST, DUTY, 4'b0111);
    wr(DEV, REG_FREQ, 32'h01, 1);
    chkPwm(DIV_SLOW, DUTY, 4'b0111);
    wr(DEV, REG_FREQ, 32'h00, 1);
    wr(DEV, REG_GLOBAL, 32'h01, 1);
    chkPwm(DIV_FAST, DUTY, 4'b0000);
    wr(DEV, REG_GLOBAL, 32'h00, 1);
    wr(DEV, REG_SHUTDOWN, 32'h00, 1);
    chkPwm(DIV_FAST, DUTY, 4'b0000);
    wr(DEV, REG_SHUTDOWN, 32'h01, 1);
    shutdownPin_n = 1'b0;
    // Pin passes two sync flops and the output register first
    repeat (4) @(negedge clk);
    chkPwm(DIV_FAST, DUTY, 4'b0000);
    shutdownPin_n = 1'b1;
    repeat (4) @(negedge clk);
    chkPwm(DIV_FAST, DUTY, 4'b0111);
    wr(DEV, REG_RESET, 32'h00, 1);
    repeat (4) @(negedge clk);
    cmp(32'(currentScaleCode), 32'h0);
    // Host steps channel 0 through gamma-corrected duty values
    wr(DEV, REG_PWM_FIRST, 32'h01, 1);
    wr(DEV, REG_PWM_FIRST, 32'h02, 1);
    wr(DEV, REG_SHUTDOWN, 32'h01, 1);
    wr(DEV, REG_UPDATE, 32'h00, 1);
    repeat (20) @(negedge clk);
    cmp(32'(currentScaleCode), 32'h0);
    cmp(32'(ledChannelOutput), 32'h0);
    end_sim();
  end
endmodule

bind lpd_top lpd_properties #(.CH(CH)) lpd_properties_inst (.clk(clk), .rst_b(rst_b),
  .sclIn(sclIn), .sdaIn(sdaIn), .sdaOe_b(sdaOe_b), .addrStrap(addrStrap),
  .shutdownPin_n(shutdownPin_n), .ledChannelOutput(ledChannelOutput),
  .currentScaleCode(currentScaleCode), .pwmCycleStart(pwmCycleStart));
